//--- core/sct_pkg.sv
// Package: timing constants, commands and states of the DDR command timing host
// What this block does
// - Read waits write-to-read delay after write data
// - MRS spacing 4 clocks, other commands 12
// - Write auto precharge: recovery plus precharge before activate
// - Activate to activate spacing max(4, 6ns)
// - At most four activates per 35ns
// - Initial calibration blocks everything max(512, 640ns)
// - Full calibration blocks everything max(256, 320ns)
// - Wait max(5, 120ns) after clock enable high
// - Self refresh exit to plain commands max(5,120ns)
// - Self refresh exit to DLL commands 512 clocks
// - Clock enable low for minimum pulse plus one
// - Clock stays valid after self refresh entry
// - Clock valid before self refresh exit
// - Column command waits activate-to-column delay
// - Same bank activate or refresh waits row cycle
package sct_pkg;

  // ****************************************
  // Clock and conversion
  // ****************************************
  localparam int CLK_PS = 20000;

  // Least times round up, never below the clock count
  function automatic int cyc_min(input int nck, input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c > nck) ? c : nck;
  endfunction

  // ****************************************
  // Timing constants
  // ****************************************
  localparam int TMR_W         = 10;
  localparam int BURST_CYC     = 4;
  localparam int CCD_CYC       = 4;
  localparam int WTR_PS        = 7500;
  localparam int WTR_CYC       = cyc_min(4, WTR_PS);
  localparam int RTP_PS        = 7500;
  localparam int RTP_CYC       = cyc_min(4, RTP_PS);
  localparam int MRD_CYC       = 4;
  localparam int MOD_PS        = 15000;
  localparam int MOD_CYC       = cyc_min(12, MOD_PS);
  localparam int MPRR_CYC      = 1;
  localparam int RRD_PS        = 6000;
  localparam int RRD_CYC       = cyc_min(4, RRD_PS);
  localparam int FAW_PS        = 35000;
  localparam int FAW_CYC       = cyc_min(1, FAW_PS);
  localparam int ZQINIT_PS     = 640000;
  localparam int ZQINIT_CYC    = cyc_min(512, ZQINIT_PS);
  localparam int ZQOPER_PS     = 320000;
  localparam int ZQOPER_CYC    = cyc_min(256, ZQOPER_PS);
  localparam int ZQCS_PS       = 80000;
  localparam int ZQCS_CYC      = cyc_min(64, ZQCS_PS);
  localparam int XPR_PS        = 120000;
  localparam int XPR_CYC       = cyc_min(5, XPR_PS);
  localparam int XS_PS         = 120000;
  localparam int XS_CYC        = cyc_min(5, XS_PS);
  localparam int DLLK_CYC      = 512;
  localparam int CKE_PS        = 5000;
  localparam int CKESR_CYC     = cyc_min(3, CKE_PS) + 1;
  localparam int CKSRE_PS      = 10000;
  localparam int CKSRE_CYC     = cyc_min(5, CKSRE_PS);
  localparam int CKSRX_PS      = 10000;
  localparam int CKSRX_CYC     = cyc_min(5, CKSRX_PS);
  localparam int SR_ENTER_CYC  = (CKSRE_CYC > CKESR_CYC) ? CKSRE_CYC : CKESR_CYC;
  localparam int RFC_PS        = 110000;
  localparam int RFC_CYC       = cyc_min(1, RFC_PS);
  // Longest times round down
  localparam int REFI_NS       = 7800;
  localparam int REFI_CYC      = REFI_NS * 1000 / CLK_PS;
  localparam int REFI_HOT_NS   = 3900;
  localparam int REFI_HOT_CYC  = REFI_HOT_NS * 1000 / CLK_PS;

  // ****************************************
  // Commands and states
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PRE, CMD_PREA,
    CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA, CMD_ZQCL, CMD_ZQCS
  } sct_cmd_type;

  typedef enum logic [2:0] {
    ST_RST, ST_CKE_WAIT, ST_RUN, ST_SR_ENTER, ST_SR_STOP, ST_SR_CLK
  } sct_state_type;

endpackage

//--- core/sct_tmr_if.sv
// Interface: load requests and idle flags between controller and timer bank
`timescale 1ns/1ns
interface sct_tmr_if #(
  parameter int N = 8,
  parameter int W = 10
);
  logic [N-1:0]        load;
  logic [N-1:0][W-1:0] val;
  logic [N-1:0]        idle;

  modport ctrl (output load, output val, input idle);
  modport tmr  (input load, input val, output idle);
endinterface

//--- core/sct_timer.sv
// Module: bank of down counters, each keeps the longest pending wait
`timescale 1ns/1ns
module sct_timer #(
  parameter int N = 8,
  parameter int W = 10
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  sct_tmr_if.tmr    tif
);

  typedef struct packed {
    logic [N-1:0][W-1:0] cnt;
  } sct_tstate_type;

  sct_tstate_type r;
  sct_tstate_type next_r;

  // ****************************************
  // Counters
  // ****************************************
  // A shorter load never cuts an older, longer wait
  always_comb
  begin
    next_r = r;
    for (int i = 0; i < N; i++)
    begin
      if (tif.load[i] && (tif.val[i] > r.cnt[i]))
        next_r.cnt[i] = tif.val[i];
      else if (r.cnt[i] != '0)
        next_r.cnt[i] = r.cnt[i] - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  for (genvar g = 0; g < N; g++)
  begin : g_idle
    assign tif.idle[g] = (r.cnt[g] == '0);
  end

endmodule

//--- core/sct_ctrl.sv
// Module: command timing host that paces requests onto the DRAM command pins
`timescale 1ns/1ns
module sct_ctrl #(
  parameter int BANKS        = 8,
  parameter int BW           = 3,
  parameter int RST_HOLD_CYC = 10000,
  parameter int CKE_WAIT_CYC = 25000,
  parameter int TRCD_PS      = 14000,
  parameter int TRP_PS       = 14000,
  parameter int TRC_PS       = 48000,
  parameter int WL_CYC       = 5,
  parameter int WR_CK        = 5
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 hot_i,
  input  wire logic                 req_valid_i,
  input  wire sct_pkg::sct_cmd_type req_cmd_i,
  input  wire logic [BW-1:0]        req_bank_i,
  output logic                      ack_o,
  output logic                      init_done_o,
  output sct_pkg::sct_cmd_type      cmd_o,
  output logic [BW-1:0]             bank_o,
  output logic                      cke_o,
  output logic                      reset_n_o,
  output logic                      ck_en_o
);

  // ****************************************
  // Timer map and derived waits
  // ****************************************
  localparam int TW     = sct_pkg::TMR_W;
  localparam int T_ALL  = 0;
  localparam int T_MOD  = 1;
  localparam int T_MRD  = 2;
  localparam int T_RD   = 3;
  localparam int T_COL  = 4;
  localparam int T_RRD  = 5;
  localparam int T_DLL  = 6;
  localparam int T_ACT0 = 7;
  localparam int T_COL0 = T_ACT0 + BANKS;
  localparam int NT     = T_COL0 + BANKS;
  localparam int RCD_CYC = sct_pkg::cyc_min(1, TRCD_PS);
  localparam int RP_CYC  = sct_pkg::cyc_min(1, TRP_PS);
  localparam int RC_CYC  = sct_pkg::cyc_min(1, TRC_PS);
  // Write waits count from the end of the burst data
  localparam int WR_END  = WL_CYC + sct_pkg::BURST_CYC;
  localparam int LD_WTR  = WR_END + sct_pkg::WTR_CYC - 1;
  localparam int LD_DAL  = WR_END + WR_CK + RP_CYC - 1;
  localparam int LD_RTP  = sct_pkg::RTP_CYC + RP_CYC - 1;

  typedef struct packed {
    sct_pkg::sct_state_type st;
    logic [15:0]            cnt;
    logic                   reset_n;
    logic                   cke;
    logic                   ck_en;
    logic                   ack;
    logic                   init_done;
    logic                   hot_s1;
    logic                   hot_s2;
    logic                   ref_due;
    logic                   zq_init_done;
    sct_pkg::sct_cmd_type   cmd;
    logic [BW-1:0]          bank;
    logic [9:0]             ref_cnt;
    logic [1:0]             faw_ptr;
    logic [3:0][7:0]        faw_cnt;
  } sct_ctl_type;

  sct_ctl_type r;
  sct_ctl_type next_r;

  sct_tmr_if #(.N(NT), .W(TW)) tif ();

  sct_timer #(.N(NT), .W(TW)) u_tmr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tif        (tif)
  );

  // ****************************************
  // Timers that must be idle per command
  // ****************************************
  function automatic logic [NT-1:0] need_mask(input sct_pkg::sct_cmd_type c, input logic [BW-1:0] b);
    logic [NT-1:0] m;
    m        = '0;
    m[T_ALL] = 1'b1;
    if (c == sct_pkg::CMD_MRS)
      m[T_MRD] = 1'b1;
    else
      m[T_MOD] = 1'b1;
    case (c)
      sct_pkg::CMD_ACT:
      begin
        m[T_RRD]           = 1'b1;
        m[T_ACT0 + int'(b)] = 1'b1;
      end
      sct_pkg::CMD_WR, sct_pkg::CMD_WRA:
      begin
        m[T_COL]            = 1'b1;
        m[T_DLL]            = 1'b1;
        m[T_COL0 + int'(b)] = 1'b1;
      end
      sct_pkg::CMD_RD, sct_pkg::CMD_RDA:
      begin
        m[T_COL]            = 1'b1;
        m[T_RD]             = 1'b1;
        m[T_DLL]            = 1'b1;
        m[T_COL0 + int'(b)] = 1'b1;
      end
      sct_pkg::CMD_REF:
        m[T_ACT0 +: BANKS] = '1;
      default:
        m = m;
    endcase
    return m;
  endfunction

  // ****************************************
  // Sequencer and issue logic
  // ****************************************
  always_comb
  begin
    logic [NT-1:0]        need;
    logic                 go;
    logic                 faw_ok;
    sct_pkg::sct_cmd_type c;
    logic [BW-1:0]        b;
    need     = '0;
    go       = 1'b0;
    faw_ok   = 1'b0;
    c        = req_cmd_i;
    b        = req_bank_i;
    next_r   = r;
    tif.load = '0;
    tif.val  = '0;
    next_r.ack    = 1'b0;
    next_r.cmd    = sct_pkg::CMD_NOP;
    next_r.hot_s1 = hot_i;
    next_r.hot_s2 = r.hot_s1;
    for (int i = 0; i < 4; i++)
    begin
      if (r.faw_cnt[i] != '0)
        next_r.faw_cnt[i] = r.faw_cnt[i] - 8'h01;
    end
    // Oldest of the last four activates must have left the window
    faw_ok = (r.faw_cnt[r.faw_ptr] == '0);
    case (r.st)
      sct_pkg::ST_RST:
      begin
        next_r.ck_en = 1'b1;
        if (r.cnt == 16'(RST_HOLD_CYC - 1))
        begin
          next_r.reset_n = 1'b1;
          next_r.cnt     = '0;
          next_r.st      = sct_pkg::ST_CKE_WAIT;
        end
        else
          next_r.cnt = r.cnt + 16'h0001;
      end
      sct_pkg::ST_CKE_WAIT:
      begin
        if (r.cnt == 16'(CKE_WAIT_CYC - 1))
        begin
          next_r.cke       = 1'b1;
          next_r.init_done = 1'b1;
          next_r.ref_cnt   = 10'(sct_pkg::REFI_CYC - 1);
          next_r.st        = sct_pkg::ST_RUN;
          tif.load[T_ALL]  = 1'b1;
          tif.val[T_ALL]   = TW'(sct_pkg::XPR_CYC - 1);
        end
        else
          next_r.cnt = r.cnt + 16'h0001;
      end
      sct_pkg::ST_RUN:
      begin
        // Hot case halves the refresh interval
        if (r.ref_cnt == '0)
        begin
          next_r.ref_due = 1'b1;
          next_r.ref_cnt = r.hot_s2 ? 10'(sct_pkg::REFI_HOT_CYC - 1) : 10'(sct_pkg::REFI_CYC - 1);
        end
        else
          next_r.ref_cnt = r.ref_cnt - 10'h001;
        need = need_mask(sct_pkg::CMD_REF, '0);
        if (r.ref_due && !r.ack && ((tif.idle & need) == need))
        begin
          go = 1'b1;
          c  = sct_pkg::CMD_REF;
          b  = '0;
          // A new due event in the same cycle is kept
          next_r.ref_due = (r.ref_cnt == '0);
        end
        else if (req_valid_i && !r.ack && !r.ref_due && (c != sct_pkg::CMD_NOP) && (c != sct_pkg::CMD_SRX))
        begin
          need = need_mask(c, b);
          if (((tif.idle & need) == need) && ((c != sct_pkg::CMD_ACT) || faw_ok))
          begin
            go         = 1'b1;
            next_r.ack = 1'b1;
          end
        end
        if (go)
        begin
          next_r.cmd  = c;
          next_r.bank = b;
          case (c)
            sct_pkg::CMD_MRS:
            begin
              tif.load[T_MRD] = 1'b1;
              tif.val[T_MRD]  = TW'(sct_pkg::MRD_CYC - 1);
              tif.load[T_MOD] = 1'b1;
              // Also covers the readout exit recovery
              tif.val[T_MOD]  = TW'(sct_pkg::MOD_CYC - 1);
            end
            sct_pkg::CMD_REF:
            begin
              tif.load[T_ALL] = 1'b1;
              tif.val[T_ALL]  = TW'(sct_pkg::RFC_CYC - 1);
            end
            sct_pkg::CMD_ZQCL:
            begin
              tif.load[T_ALL] = 1'b1;
              tif.val[T_ALL]  = r.zq_init_done ? TW'(sct_pkg::ZQOPER_CYC - 1)
                                               : TW'(sct_pkg::ZQINIT_CYC - 1);
              next_r.zq_init_done = 1'b1;
            end
            sct_pkg::CMD_ZQCS:
            begin
              tif.load[T_ALL] = 1'b1;
              tif.val[T_ALL]  = TW'(sct_pkg::ZQCS_CYC - 1);
            end
            sct_pkg::CMD_PRE:
            begin
              tif.load[T_ACT0 + int'(b)] = 1'b1;
              tif.val[T_ACT0 + int'(b)]  = TW'(RP_CYC - 1);
            end
            sct_pkg::CMD_PREA:
            begin
              for (int i = 0; i < BANKS; i++)
              begin
                tif.load[T_ACT0 + i] = 1'b1;
                tif.val[T_ACT0 + i]  = TW'(RP_CYC - 1);
              end
            end
            sct_pkg::CMD_ACT:
            begin
              tif.load[T_ACT0 + int'(b)] = 1'b1;
              tif.val[T_ACT0 + int'(b)]  = TW'(RC_CYC - 1);
              tif.load[T_COL0 + int'(b)] = 1'b1;
              tif.val[T_COL0 + int'(b)]  = TW'(RCD_CYC - 1);
              tif.load[T_RRD]            = 1'b1;
              tif.val[T_RRD]             = TW'(sct_pkg::RRD_CYC - 1);
              next_r.faw_cnt[r.faw_ptr]  = 8'(sct_pkg::FAW_CYC - 1);
              next_r.faw_ptr             = r.faw_ptr + 2'h1;
            end
            sct_pkg::CMD_WR, sct_pkg::CMD_WRA:
            begin
              tif.load[T_COL] = 1'b1;
              tif.val[T_COL]  = TW'(sct_pkg::CCD_CYC - 1);
              tif.load[T_RD]  = 1'b1;
              tif.val[T_RD]   = TW'(LD_WTR);
              if (c == sct_pkg::CMD_WRA)
              begin
                tif.load[T_ACT0 + int'(b)] = 1'b1;
                tif.val[T_ACT0 + int'(b)]  = TW'(LD_DAL);
              end
            end
            sct_pkg::CMD_RD, sct_pkg::CMD_RDA:
            begin
              tif.load[T_COL] = 1'b1;
              tif.val[T_COL]  = TW'(sct_pkg::CCD_CYC - 1);
              if (c == sct_pkg::CMD_RDA)
              begin
                tif.load[T_ACT0 + int'(b)] = 1'b1;
                tif.val[T_ACT0 + int'(b)]  = TW'(LD_RTP);
              end
            end
            sct_pkg::CMD_SRE:
            begin
              next_r.cke = 1'b0;
              next_r.cnt = 16'(sct_pkg::SR_ENTER_CYC - 1);
              next_r.st  = sct_pkg::ST_SR_ENTER;
            end
            default:
              next_r.cmd = c;
          endcase
        end
      end
      sct_pkg::ST_SR_ENTER:
      begin
        // Clock must keep running until the entry wait ends
        if (r.cnt == '0)
        begin
          next_r.ck_en = 1'b0;
          next_r.st    = sct_pkg::ST_SR_STOP;
        end
        else
          next_r.cnt = r.cnt - 16'h0001;
      end
      sct_pkg::ST_SR_STOP:
      begin
        if (req_valid_i && (c == sct_pkg::CMD_SRX))
        begin
          next_r.ck_en = 1'b1;
          next_r.cnt   = 16'(sct_pkg::CKSRX_CYC - 1);
          next_r.st    = sct_pkg::ST_SR_CLK;
        end
      end
      sct_pkg::ST_SR_CLK:
      begin
        if (r.cnt == '0)
        begin
          next_r.cke      = 1'b1;
          next_r.cmd      = sct_pkg::CMD_SRX;
          next_r.ack      = 1'b1;
          next_r.st       = sct_pkg::ST_RUN;
          tif.load[T_ALL] = 1'b1;
          tif.val[T_ALL]  = TW'(sct_pkg::XS_CYC - 1);
          tif.load[T_DLL] = 1'b1;
          tif.val[T_DLL]  = TW'(sct_pkg::DLLK_CYC - 1);
        end
        else
          next_r.cnt = r.cnt - 16'h0001;
      end
      default:
        next_r.st = sct_pkg::ST_RST;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign ack_o       = r.ack;
  assign init_done_o = r.init_done;
  assign cmd_o       = r.cmd;
  assign bank_o      = r.bank;
  assign cke_o       = r.cke;
  assign reset_n_o   = r.reset_n;
  assign ck_en_o     = r.ck_en;

endmodule

//--- bench/sct_monitor.sv
// Checker: command spacing seen on the DRAM pins of the timing host
`timescale 1ns/1ns
module sct_monitor (
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire logic                 init_done_o,
  input wire sct_pkg::sct_cmd_type cmd_o,
  input wire logic                 cke_o,
  input wire logic                 ck_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Counters since the last command of a kind
  // ****************************************
  logic [9:0] since_mrs;
  logic [9:0] since_wr;
  logic [9:0] busy;
  logic       zq_seen;
  logic       col;
  logic       idle;
  assign col = cmd_o inside {sct_pkg::CMD_WR, sct_pkg::CMD_WRA, sct_pkg::CMD_RD, sct_pkg::CMD_RDA};
  assign idle = (cmd_o == sct_pkg::CMD_NOP);

  // Saturate so a long quiet spell never wraps into a short gap
  function automatic logic [9:0] inc(input logic [9:0] v);
    return (v == 10'h3ff) ? v : v + 10'h001;
  endfunction

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      since_mrs <= 10'h3ff;
      since_wr  <= 10'h3ff;
      busy      <= 10'h000;
      zq_seen   <= 1'b0;
    end
    else
    begin
      since_mrs <= (cmd_o == sct_pkg::CMD_MRS) ? 10'h001 : inc(since_mrs);
      since_wr  <= (cmd_o inside {sct_pkg::CMD_WR, sct_pkg::CMD_WRA}) ? 10'h001 : inc(since_wr);
      if (cmd_o == sct_pkg::CMD_ZQCL)
        zq_seen <= 1'b1;
      if (cmd_o == sct_pkg::CMD_ZQCL)
        busy <= zq_seen ? 10'h0ff : 10'h1ff;
      else if (cmd_o == sct_pkg::CMD_ZQCS)
        busy <= 10'h03f;
      else if (cmd_o == sct_pkg::CMD_REF || cmd_o == sct_pkg::CMD_SRX)
        busy <= 10'h005;
      else if (busy != 10'h000)
        busy <= busy - 10'h001;
    end
  end

  // ****************************************
  // Spacing properties
  // ****************************************
  a_mrs_mrs_gap: assert property (cmd_o == sct_pkg::CMD_MRS |=> (cmd_o != sct_pkg::CMD_MRS) [*3])
    else $error("mode sets too close");
  a_mrs_other_gap: assert property (!idle && cmd_o != sct_pkg::CMD_MRS |-> since_mrs >= 10'h00c)
    else $error("command too soon after mode set");
  a_act_act_gap: assert property (cmd_o == sct_pkg::CMD_ACT |=> (cmd_o != sct_pkg::CMD_ACT) [*3])
    else $error("activates too close");
  a_col_col_gap: assert property (col |=> !col [*3])
    else $error("column commands too close");
  a_wr_rd_gap: assert property (cmd_o inside {sct_pkg::CMD_RD, sct_pkg::CMD_RDA} |-> since_wr >= 10'h00d)
    else $error("read too soon after write");
  a_cal_quiet: assert property (busy != 10'h000 |-> idle)
    else $error("command during calibration or refresh");
  a_xpr_wait: assert property ($rose(init_done_o) |-> cke_o && idle [*6])
    else $error("command too soon after clock enable");
  a_sre_clock: assert property (cmd_o == sct_pkg::CMD_SRE |-> !cke_o && ck_en_o [*5] ##1 !ck_en_o)
    else $error("clock stopped too early after entry");
  a_srx_entry: assert property (cmd_o == sct_pkg::CMD_SRX |-> $past(ck_en_o, 5) && !$past(cke_o, 4))
    else $error("exit without valid clock or low enable");
endmodule

//--- bench/sct_dram_model.sv
// Model: DRAM device side, calibration busy time and enable legality
`timescale 1ns/1ns
module sct_dram_model (
  input  wire logic                 core_clk_i,
  input  wire sct_pkg::sct_cmd_type cmd_i,
  input  wire logic                 cke_i,
  input  wire logic                 reset_n_i,
  output int                        viol_o
);
  int cal_left;
  bit cal_first;
  initial viol_o = 0;
  always @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      cal_left = 0;
      cal_first = 1'b1;
    end
    else if (cal_left > 0)
    begin
      // Device is calibrating and ignores the bus
      if (cmd_i != sct_pkg::CMD_NOP)
        viol_o++;
      cal_left--;
    end
    else if (cmd_i == sct_pkg::CMD_ZQCL)
    begin
      cal_left = cal_first ? sct_pkg::ZQINIT_CYC - 1 : sct_pkg::ZQOPER_CYC - 1;
      cal_first = 1'b0;
    end
    else if (cmd_i == sct_pkg::CMD_ZQCS)
      cal_left = sct_pkg::ZQCS_CYC - 1;
    else if (!cke_i && !(cmd_i inside {sct_pkg::CMD_NOP, sct_pkg::CMD_SRE, sct_pkg::CMD_SRX}))
      viol_o++;
  end
endmodule

//--- bench/tb_sdram_command_timing_rules.sv
// Testbench: scenarios and verdict for the command timing host
`timescale 1ns/1ns
module tb_sdram_command_timing_rules;
  localparam int BW = 3;
  localparam int WL = 5;
  // Slow activate-to-column bin so the ack cycle alone cannot hide a missed wait
  localparam int RCD = 3;
  logic                 core_clk_i;
  logic                 rst_i;
  logic                 hot_i;
  logic                 req_valid_i;
  sct_pkg::sct_cmd_type req_cmd_i;
  logic [BW-1:0]        req_bank_i;
  logic                 ack_o;
  logic                 init_done_o;
  sct_pkg::sct_cmd_type cmd_o;
  logic [BW-1:0]        bank_o;
  logic                 cke_o;
  logic                 reset_n_o;
  logic                 ck_en_o;
  int                   viol;
  int                   cyc = 0;
  int                   ck_rise = 0;
  logic                 ck_prev = 1'b0;
  int                   error_cnt = 0;
  int                   checks_done = 0;

  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    #1;
    if (ck_en_o === 1'b1 && ck_prev !== 1'b1)
      ck_rise = cyc;
    ck_prev = ck_en_o;
  end

  sct_ctrl #(.RST_HOLD_CYC(8), .CKE_WAIT_CYC(8), .TRCD_PS(RCD * sct_pkg::CLK_PS)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hot_i(hot_i), .req_valid_i(req_valid_i),
    .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i), .ack_o(ack_o), .init_done_o(init_done_o),
    .cmd_o(cmd_o), .bank_o(bank_o), .cke_o(cke_o), .reset_n_o(reset_n_o), .ck_en_o(ck_en_o));
  sct_dram_model u_dram (.core_clk_i(core_clk_i), .cmd_i(cmd_o), .cke_i(cke_o), .reset_n_i(reset_n_o),
    .viol_o(viol));

  // ****************************************
  // Report, compare and bus tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A used-up wait counts as a mismatch and ends the run
  task automatic limit_hit(input int n, input int lim);
    if (n >= lim)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int seen);
    checks_done++;
    if (seen < lo || seen > hi)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask
  // Leaves the request up: the caller may change it in the ack cycle
  task automatic issue(input sct_pkg::sct_cmd_type c, input logic [BW-1:0] b, output int at);
    int n;
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_bank_i = b;
    n = 0;
    do
    begin
      step();
      n++;
    end while (ack_o !== 1'b1 && n < 2000);
    limit_hit(n, 2000);
    chk_bit("command and bank on pins", 1'b1, cmd_o === c && bank_o === b);
    at = cyc;
  endtask
  task automatic next_ref(output int at);
    int n;
    n = 0;
    do
    begin
      step();
      n++;
    end while (cmd_o !== sct_pkg::CMD_REF && n < 1000);
    limit_hit(n, 1000);
    at = cyc;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic do_reset();
    req_valid_i = 1'b0;
    rst_i = 1'b1;
    repeat (12) step();
    rst_i = 1'b0;
  endtask
  task automatic t_init();
    int n;
    int a;
    n = 0;
    while (init_done_o !== 1'b1 && n < 200)
    begin
      step();
      n++;
    end
    limit_hit(n, 200);
    chk_bit("enable with init done", 1'b1, cke_o && reset_n_o);
    n = cyc;
    issue(sct_pkg::CMD_MRS, '0, a);
    chk_rng("first command after enable", sct_pkg::XPR_CYC, 1000, a - n);
    req_valid_i = 1'b0;
  endtask
  task automatic t_rows();
    int a, b, w, r;
    int acts[5];
    step();
    issue(sct_pkg::CMD_MRS, '0, a);
    issue(sct_pkg::CMD_MRS, '0, b);
    chk_rng("mode set spacing", sct_pkg::MRD_CYC, 1000, b - a);
    issue(sct_pkg::CMD_ACT, '0, acts[0]);
    chk_rng("mode set to activate", sct_pkg::MOD_CYC, 1000, acts[0] - b);
    for (int i = 1; i < 5; i++)
    begin
      issue(sct_pkg::CMD_ACT, BW'(i), acts[i]);
      chk_rng("activate spacing", sct_pkg::RRD_CYC, 1000, acts[i] - acts[i-1]);
    end
    chk_rng("four activate window", sct_pkg::FAW_CYC, 4000, acts[4] - acts[0]);
    issue(sct_pkg::CMD_WR, 3'h4, w);
    chk_rng("activate to write", RCD, 1000, w - acts[4]);
    issue(sct_pkg::CMD_WR, 3'h1, a);
    chk_rng("column spacing", sct_pkg::CCD_CYC, 1000, a - w);
    issue(sct_pkg::CMD_RD, '0, r);
    chk_rng("write to read", WL + sct_pkg::BURST_CYC + sct_pkg::WTR_CYC, 1000, r - a);
    issue(sct_pkg::CMD_WRA, '0, w);
    issue(sct_pkg::CMD_ACT, '0, a);
    chk_rng("auto precharge to activate", WL + sct_pkg::BURST_CYC + 6, 1000, a - w);
    req_valid_i = 1'b0;
  endtask
  task automatic t_cal();
    int a, b;
    step();
    issue(sct_pkg::CMD_ZQCL, '0, a);
    issue(sct_pkg::CMD_MRS, '0, b);
    chk_rng("initial calibration", sct_pkg::ZQINIT_CYC, 2000, b - a);
    issue(sct_pkg::CMD_ZQCL, '0, a);
    issue(sct_pkg::CMD_MRS, '0, b);
    chk_rng("full calibration", sct_pkg::ZQOPER_CYC, 2000, b - a);
    issue(sct_pkg::CMD_ZQCS, '0, a);
    issue(sct_pkg::CMD_MRS, '0, b);
    chk_rng("short calibration", sct_pkg::ZQCS_CYC, 2000, b - a);
    req_valid_i = 1'b0;
  endtask
  task automatic t_self();
    int s, x, a, n;
    step();
    issue(sct_pkg::CMD_SRE, '0, s);
    req_valid_i = 1'b0;
    chk_bit("enable low on entry", 1'b0, cke_o);
    n = 0;
    while (ck_en_o === 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    limit_hit(n, 20);
    chk_rng("clock kept after entry", sct_pkg::CKSRE_CYC, 19, n);
    repeat (3) step();
    issue(sct_pkg::CMD_SRX, '0, x);
    chk_rng("clock before exit", sct_pkg::CKSRX_CYC, 1000, x - ck_rise);
    chk_rng("enable low width", sct_pkg::CKESR_CYC, 1000, x - s);
    issue(sct_pkg::CMD_ACT, 3'h6, a);
    chk_rng("exit to plain command", sct_pkg::XS_CYC, 1000, a - x);
    issue(sct_pkg::CMD_RD, 3'h6, a);
    chk_rng("exit to locked loop command", sct_pkg::DLLK_CYC, 2000, a - x);
    req_valid_i = 1'b0;
  endtask
  task automatic t_refresh();
    int r0, r1;
    next_ref(r0);
    next_ref(r1);
    chk_rng("refresh interval", sct_pkg::RFC_CYC, sct_pkg::REFI_CYC, r1 - r0);
    hot_i = 1'b1;
    repeat (4) step();
    next_ref(r0);
    next_ref(r1);
    chk_rng("hot refresh interval", sct_pkg::RFC_CYC, sct_pkg::REFI_HOT_CYC, r1 - r0);
  endtask

  initial
  begin
    rst_i = 1'b1;
    hot_i = 1'b0;
    req_valid_i = 1'b0;
    req_cmd_i = sct_pkg::CMD_NOP;
    req_bank_i = '0;
    do_reset();
    t_init();
    t_rows();
    t_cal();
    t_self();
    t_refresh();
    do_reset();
    t_init();
    chk_rng("device protocol faults", 0, 0, viol);
    summarize();
  end
endmodule

bind sct_ctrl sct_monitor u_mon (.core_clk_i(core_clk_i), .rst_i(rst_i), .init_done_o(init_done_o),
  .cmd_o(cmd_o), .cke_o(cke_o), .ck_en_o(ck_en_o));
